/* i2c_b_ctrl.v */
// Two-wire master/slave controller with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "i2c_b_defines.vh"
module i2c_b_ctrl
(
  input wire sys_clk,
  input wire resetn,
  input wire [9:0] awaddr,
  input wire [2:0] awprot,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [9:0] araddr,
  input wire [2:0] arprot,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe
);
  // One-hot protocol states
  localparam [12:0] ST_IDLE = 13'h0001;
  localparam [12:0] ST_MSTART = 13'h0002;
  localparam [12:0] ST_MRST = 13'h0004;
  localparam [12:0] ST_MBIT = 13'h0008;
  localparam [12:0] ST_MSTOP = 13'h0010;
  localparam [12:0] ST_MWAIT = 13'h0020;
  localparam [12:0] ST_SADDR = 13'h0040;
  localparam [12:0] ST_SADDR2 = 13'h0080;
  localparam [12:0] ST_SRX = 13'h0100;
  localparam [12:0] ST_STX = 13'h0200;
  localparam [12:0] ST_SACK = 13'h0400;
  localparam [12:0] ST_SACKW = 13'h0800;
  localparam [12:0] ST_SHOLD = 13'h1000;
  // Reset words, sliced into the fields they cover
  localparam [7:0] INT_RST_W = `RST_INT;
  localparam [7:0] CR2_RST_W = `RST_CR2;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg aw_h_r, w_h_r; // Write address and data held
  reg [9:0] awaddr_r; // Held write address
  reg [7:0] wdata_r; // Held write byte
  reg wstrb_r; // Held lane 0 strobe
  reg tx_ev_r, rx_ev_r, stop_ie_r, stop_flag_r; // Event register
  reg strobe_r, role_r, speed_r, stop_req_r; // Control register 1
  reg addr_sent_r, ack_r, full_r, empty_r; // Status register 1
  reg slave_busy_r, soft_rst_n_r, bus_busy_r, enable_r; // Register 2
  reg [2:0] div_sel_r; // Divider select
  reg [7:0] target_addr_r; // Target address and direction
  reg [7:0] data_buf_r; // Data buffer
  reg [7:0] own_lo_r; // Own address low byte
  reg [2:0] own_hi_r; // Sync select and own address 9:8
  reg [12:0] state_r; // Protocol state
  reg [3:0] bit_cnt_r; // Bit counter
  reg [7:0] shift_r; // Shift register
  reg is_addr_r, rd_mode_r; // Master byte kind
  reg slv_dir_r, acc_r, go_a2_r, ten_r; // Slave session state
  reg scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3; // Synchronisers
  reg scl_p, sda_p; // Previous sampled levels
  reg [7:0] rd_mux; // Read data select
  reg rd_map; // Read address mapped
  reg acc_nxt, a2_nxt, dir_nxt; // Slave byte decision
  wire tick_w; // Master phase tick
  wire [1:0] phase_w; // Master phase
  wire run_w = enable_r & soft_rst_n_r;
  wire [7:0] wr_idx = awaddr_r[9:2];
  wire [7:0] rd_idx = araddr[9:2];
  wire wr_go = aw_h_r & w_h_r & ~bvalid;
  wire wr_en = wr_go & wstrb_r;
  wire rd_go = arvalid & arready;
  wire scl_c = own_hi_r[2] ? scl_s3 : scl_s2;
  wire sda_c = own_hi_r[2] ? sda_s3 : sda_s2;
  wire rise = scl_c & ~scl_p;
  wire fall = ~scl_c & scl_p;
  wire start_det = scl_c & scl_p & sda_p & ~sda_c;
  wire stop_det = scl_c & scl_p & ~sda_p & sda_c;
  wire hdr_w = (shift_r[7:3] == `TEN_BIT_HDR) && (shift_r[2:1] == own_hi_r[1:0]);
  wire m7_w = (shift_r[7:3] != `TEN_BIT_HDR) && (shift_r[7:1] == own_lo_r[6:0]);
  // Begin a byte only at a period end, so START and bit 7 get their full quarters
  wire m_load = role_r & strobe_r & tick_w & (phase_w == 2'h3) &
                ((state_r == ST_IDLE) & ~bus_busy_r | (state_r == ST_MWAIT) & scl_oe);

  // Register index decode shared by both channels
  function mapped;
    input [7:0] idx;
    begin
      mapped = (idx == `IDX_INT) | (idx == `IDX_CR1) | (idx == `IDX_CR2) |
               (idx == `IDX_TA) | (idx == `IDX_DB) | (idx == `IDX_OAL) | (idx == `IDX_OAH);
    end
  endfunction

  // ----------------------------------------
  // SCL timing
  // ----------------------------------------
  scl_tick_gen scl_tick_gen_i
  (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .run(run_w & role_r),
    .speed(speed_r),
    .div_sel(div_sel_r),
    .tick(tick_w),
    .phase(phase_w)
  );

  // ----------------------------------------
  // Read mux and slave byte decision
  // ----------------------------------------
  // Register readback
  always @*
  begin
    rd_map = mapped(rd_idx);
    case (rd_idx)
      `IDX_INT: rd_mux = {tx_ev_r, rx_ev_r, stop_ie_r, stop_flag_r, 4'h0};
      `IDX_CR1: rd_mux = {strobe_r, role_r, speed_r, stop_req_r,
                          addr_sent_r, ack_r, full_r, empty_r};
      `IDX_CR2: rd_mux = {slave_busy_r, 1'h0, soft_rst_n_r, bus_busy_r, div_sel_r, enable_r};
      `IDX_TA: rd_mux = target_addr_r;
      `IDX_DB: rd_mux = data_buf_r;
      `IDX_OAL: rd_mux = own_lo_r;
      `IDX_OAH: rd_mux = {5'h00, own_hi_r};
      default: rd_mux = 8'h00;
    endcase
  end

  // Accept or refuse the byte just shifted in
  always @*
  begin
    acc_nxt = 1'h0;
    a2_nxt = 1'h0;
    dir_nxt = 1'h0;
    case (state_r)
      ST_SADDR:
      begin
        acc_nxt = (hdr_w & (~shift_r[0] | ten_r)) | m7_w;
        a2_nxt = hdr_w & ~shift_r[0];
        dir_nxt = shift_r[0];
      end
      ST_SADDR2: acc_nxt = (shift_r == own_lo_r);
      ST_SRX: acc_nxt = ~stop_req_r;
      default: acc_nxt = 1'h0;
    endcase
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Two stages, a third for the sync option
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {scl_s1, scl_s2, scl_s3, scl_p} <= 4'hf;
      {sda_s1, sda_s2, sda_s3, sda_p} <= 4'hf;
    end
    else
    begin
      {scl_s1, scl_s2, scl_s3, scl_p} <= {scl_in, scl_s1, scl_s2, scl_c};
      {sda_s1, sda_s2, sda_s3, sda_p} <= {sda_in, sda_s1, sda_s2, sda_c};
    end
  end

  // ----------------------------------------
  // AXI4-Lite channels
  // ----------------------------------------
  // Address, data, response and read handshakes
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {awready, wready, arready} <= 3'h7;
      {aw_h_r, w_h_r, bvalid, rvalid} <= 4'h0;
      awaddr_r <= 10'h000;
      wdata_r <= 8'h00;
      wstrb_r <= 1'h0;
      bresp <= `RESP_OKAY;
      rresp <= `RESP_OKAY;
      rdata <= 32'h00000000;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awaddr_r <= awaddr;
        aw_h_r <= 1'h1;
        awready <= 1'h0;
      end
      if (wvalid && wready)
      begin
        wdata_r <= wdata[7:0];
        wstrb_r <= wstrb[0];
        w_h_r <= 1'h1;
        wready <= 1'h0;
      end
      if (wr_go)
      begin
        bvalid <= 1'h1;
        bresp <= mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        {bvalid, aw_h_r, w_h_r} <= 3'h0;
        {awready, wready} <= 2'h3;
      end
      if (rd_go)
      begin
        rvalid <= 1'h1;
        arready <= 1'h0;
        rdata <= {24'h000000, rd_mux};
        rresp <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid && rready)
      begin
        rvalid <= 1'h0;
        arready <= 1'h1;
      end
    end
  end

  // ----------------------------------------
  // Registers and protocol machine
  // ----------------------------------------
  // Software effects first, hardware after so a set wins
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {tx_ev_r, rx_ev_r, stop_ie_r, stop_flag_r} <= INT_RST_W[7:4];
      {strobe_r, role_r, speed_r, stop_req_r, addr_sent_r, ack_r, full_r, empty_r} <= `RST_CR1;
      {slave_busy_r, soft_rst_n_r, bus_busy_r, div_sel_r, enable_r} <= {CR2_RST_W[7],
                                                                       CR2_RST_W[5:0]};
      target_addr_r <= `RST_TA;
      data_buf_r <= `RST_DB;
      own_lo_r <= `RST_OAL;
      own_hi_r <= `RST_OAH;
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      {is_addr_r, rd_mode_r, slv_dir_r, acc_r, go_a2_r, ten_r} <= 6'h00;
      {scl_oe, sda_oe, scl_out, sda_out} <= 4'h0;
    end
    else
    begin
      if (wr_en)
      begin
        case (wr_idx)
          `IDX_INT:
          begin
            tx_ev_r <= tx_ev_r & wdata_r[`INT_TX];
            rx_ev_r <= rx_ev_r & wdata_r[`INT_RX];
            stop_ie_r <= wdata_r[`INT_SIE];
          end
          `IDX_CR1:
          begin
            strobe_r <= wdata_r[`CR1_STROBE];
            role_r <= wdata_r[`CR1_ROLE];
            speed_r <= wdata_r[`CR1_SPEED];
            stop_req_r <= wdata_r[`CR1_STOP];
          end
          `IDX_CR2:
          begin
            soft_rst_n_r <= wdata_r[`CR2_SRST];
            div_sel_r <= wdata_r[`CR2_SEL_HI:`CR2_SEL_LO];
            enable_r <= wdata_r[`CR2_EN];
          end
          `IDX_TA:
          begin
            target_addr_r <= wdata_r;
            addr_sent_r <= 1'h0;
          end
          `IDX_DB:
          begin
            data_buf_r <= wdata_r;
            empty_r <= 1'h0;
          end
          `IDX_OAL: own_lo_r <= wdata_r;
          `IDX_OAH: own_hi_r <= wdata_r[2:0];
          default: own_hi_r <= own_hi_r;
        endcase
      end
      if (rd_go && rd_idx == `IDX_DB)
        full_r <= 1'h0;
      if (!run_w)
      begin
        // Disabled or soft reset: idle, lines released
        state_r <= ST_IDLE;
        {scl_oe, sda_oe} <= 2'h0;
        bit_cnt_r <= 4'h0;
        {slave_busy_r, bus_busy_r, ten_r} <= 3'h0;
      end
      else
      begin
        // Bus activity seen on the wires
        if (start_det)
          bus_busy_r <= 1'h1;
        if (stop_det)
          bus_busy_r <= 1'h0;
        if (role_r)
        begin
          if (m_load)
          begin
            // Start a byte: address if not yet sent
            state_r <= (state_r == ST_IDLE) ? ST_MSTART : (addr_sent_r ? ST_MBIT : ST_MRST);
            is_addr_r <= ~addr_sent_r;
            shift_r <= addr_sent_r ? data_buf_r : target_addr_r;
            rd_mode_r <= addr_sent_r & target_addr_r[0];
            bit_cnt_r <= 4'h0;
          end
          else if (tick_w)
          begin
            case (state_r)
              ST_MSTART:
              begin
                if (phase_w == 2'h1)
                  sda_oe <= 1'h1;
                if (phase_w == 2'h3)
                  state_r <= ST_MBIT;
              end
              ST_MRST:
              begin
                if (phase_w == 2'h1)
                  sda_oe <= 1'h0;
                if (phase_w == 2'h2)
                  scl_oe <= 1'h0;
                if (phase_w == 2'h3)
                  state_r <= ST_MSTART;
              end
              ST_MBIT:
              begin
                case (phase_w)
                  2'h0: scl_oe <= 1'h1;
                  2'h1: sda_oe <= (bit_cnt_r == 4'h8) ? (rd_mode_r & ~stop_req_r) :
                                  (~rd_mode_r & ~shift_r[7]);
                  2'h2: scl_oe <= 1'h0;
                  default:
                  begin
                    if (bit_cnt_r != 4'h8)
                    begin
                      shift_r <= {shift_r[6:0], sda_c};
                      bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    else
                    begin
                      // Handshake done: byte complete
                      strobe_r <= 1'h0;
                      stop_flag_r <= stop_req_r;
                      if (rd_mode_r)
                      begin
                        data_buf_r <= shift_r;
                        full_r <= 1'h1;
                        rx_ev_r <= 1'h1;
                      end
                      else
                      begin
                        ack_r <= ~sda_c;
                        tx_ev_r <= 1'h1;
                        if (is_addr_r)
                          addr_sent_r <= 1'h1;
                        else
                          empty_r <= 1'h1;
                      end
                      state_r <= stop_req_r ? ST_MSTOP : ST_MWAIT;
                    end
                  end
                endcase
              end
              ST_MSTOP:
              begin
                case (phase_w)
                  2'h0: scl_oe <= 1'h1;
                  2'h1: sda_oe <= 1'h1;
                  2'h2: scl_oe <= 1'h0;
                  default:
                  begin
                    sda_oe <= 1'h0;
                    stop_req_r <= 1'h0;
                    state_r <= ST_IDLE;
                  end
                endcase
              end
              ST_MWAIT:
              begin
                if (phase_w == 2'h0)
                  scl_oe <= 1'h1;
              end
              default: state_r <= ST_IDLE;
            endcase
          end
        end
        else if (stop_det)
        begin
          // Master ended the session
          state_r <= ST_IDLE;
          {scl_oe, sda_oe} <= 2'h0;
          {slave_busy_r, ten_r} <= 2'h0;
        end
        else if (start_det)
        begin
          state_r <= ST_SADDR;
          bit_cnt_r <= 4'h0;
          sda_oe <= 1'h0;
        end
        else
        begin
          case (state_r)
            ST_SADDR, ST_SADDR2, ST_SRX:
            begin
              if (rise)
              begin
                shift_r <= {shift_r[6:0], sda_c};
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
              if (fall && bit_cnt_r == 4'h8)
              begin
                // Decide ACK for the byte
                bit_cnt_r <= 4'h0;
                state_r <= ST_SACK;
                acc_r <= acc_nxt;
                go_a2_r <= a2_nxt;
                sda_oe <= acc_nxt;
                if ((acc_nxt & ~a2_nxt) | (state_r == ST_SRX))
                begin
                  data_buf_r <= shift_r;
                  full_r <= 1'h1;
                  rx_ev_r <= 1'h1;
                  stop_flag_r <= stop_req_r;
                end
                if (state_r != ST_SRX)
                begin
                  slave_busy_r <= acc_nxt;
                  if (acc_nxt & ~a2_nxt)
                    slv_dir_r <= dir_nxt;
                  if (state_r == ST_SADDR2)
                    ten_r <= acc_nxt;
                end
              end
            end
            ST_SACK:
            begin
              if (fall)
              begin
                sda_oe <= 1'h0;
                if (go_a2_r)
                  state_r <= ST_SADDR2;
                else if (!acc_r)
                  state_r <= ST_IDLE;
                else
                begin
                  strobe_r <= 1'h1;
                  scl_oe <= 1'h1;
                  state_r <= ST_SHOLD;
                end
              end
            end
            ST_SHOLD:
            begin
              if (!strobe_r)
              begin
                // Pend cleared: release SCL
                scl_oe <= 1'h0;
                bit_cnt_r <= 4'h0;
                shift_r <= data_buf_r;
                sda_oe <= slv_dir_r & ~data_buf_r[7];
                state_r <= slv_dir_r ? ST_STX : ST_SRX;
              end
            end
            ST_STX:
            begin
              if (fall)
              begin
                if (bit_cnt_r == 4'h7)
                begin
                  sda_oe <= 1'h0;
                  bit_cnt_r <= 4'h0;
                  state_r <= ST_SACKW;
                end
                else
                begin
                  shift_r <= {shift_r[6:0], 1'h0};
                  sda_oe <= ~shift_r[6];
                  bit_cnt_r <= bit_cnt_r + 4'h1;
                end
              end
            end
            ST_SACKW:
            begin
              if (rise)
                ack_r <= ~sda_c;
              if (fall)
              begin
                if (ack_r)
                begin
                  tx_ev_r <= 1'h1;
                  empty_r <= 1'h1;
                  stop_flag_r <= stop_req_r;
                  strobe_r <= 1'h1;
                  scl_oe <= 1'h1;
                  state_r <= ST_SHOLD;
                end
                else
                  state_r <= ST_IDLE;
              end
            end
            default:
            begin
              scl_oe <= 1'h0;
              sda_oe <= 1'h0;
            end
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

/* i2c_b_ctrl_chk.sv */
// Checker for the register bus handshakes of the controller
`timescale 1ns/1ps
`default_nettype none
module i2c_b_ctrl_chk
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered next cycle");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped early");
  a_read_done: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read answer not retired");
  a_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read address open while answer pending");
  a_write_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write answer dropped early");
  a_write_done: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write answer not retired");
  a_write_block: assert property (bvalid |-> !awready && !wready)
    else $error("write channels open while answer pending");
endmodule
bind i2c_b_ctrl i2c_b_ctrl_chk i2c_b_ctrl_chk_i (.sys_clk, .resetn, .awready, .wready,
  .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata);
`default_nettype wire

/* i2c_b_defines.vh */
// Constants for the second two-wire controller: offsets, fields, resets, dividers
// How it works
// - Master strobe clocks one byte, self-clears after handshake
// - Slave pend holds SCL until software clears
// - Role bit: 0 slave, 1 master
// - Speed bit: 0 standard, 1 fast
// - Master read with stop: NACK then STOP
// - Master write with stop: STOP after ACK
// - Stop request self-clears after STOP driven
// - Slave written with stop request answers NACK
// - Address sent flag, cleared by address write
// - Ack bit follows far ACK or NACK
// - Full set on receive, cleared by read
// - Empty set after sent byte, cleared by write
// - Slave busy set in transaction, cleared otherwise
// - Low soft reset resets machine, releases SCL
// - Bus busy between START and STOP
// - Fast mode dividers 10 to 60
// - Standard mode dividers 40 to 240
// - Enable bit, resets to zero
// - Target address bits 7:1, direction bit 0
// - Data buffer for both directions, resets ones
// - Event flags and stop interrupt enable
// - Stop flag hardware-only, captured at events
// - Direction 0 writes, 1 reads
// - Slave 10-bit own address, sync select
`ifndef I2C_B_DEFINES_VH
`define I2C_B_DEFINES_VH
// ----------------------------------------
// Register indices (byte address is four times)
// ----------------------------------------
`define IDX_INT 8'hd7
`define IDX_CR1 8'hd9
`define IDX_CR2 8'hda
`define IDX_TA 8'hdb
`define IDX_DB 8'hdc
`define IDX_OAL 8'hdd
`define IDX_OAH 8'hde
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_INT 8'h00
`define RST_CR1 8'h09
`define RST_CR2 8'h20
`define RST_TA 8'h01
`define RST_DB 8'hff
`define RST_OAL 8'h00
`define RST_OAH 3'h0
// ----------------------------------------
// Field positions
// ----------------------------------------
`define INT_TX 7
`define INT_RX 6
`define INT_SIE 5
`define CR1_STROBE 7
`define CR1_ROLE 6
`define CR1_SPEED 5
`define CR1_STOP 4
`define CR2_SRST 5
`define CR2_SEL_HI 3
`define CR2_SEL_LO 1
`define CR2_EN 0
// ----------------------------------------
// Divider table and misc codes
// ----------------------------------------
`define DIV_F0 8'd10
`define DIV_F1 8'd15
`define DIV_F2 8'd20
`define DIV_F3 8'd25
`define DIV_F4 8'd30
`define DIV_F5 8'd40
`define DIV_F6 8'd50
`define DIV_F7 8'd60
`define DIV_STD_SHIFT 2
`define TEN_BIT_HDR 5'h1e
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* i2c_b_slave_model.sv */
// Behavioural slave on the two-wire bus: acks address, stores writes, serves reads
`timescale 1ns/1ps
`default_nettype none
module i2c_b_slave_model
(
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] tx_byte,
  output logic sda_low,
  output logic [7:0] got,
  output logic nack_seen
);
  logic [3:0] cnt;
  logic [7:0] sh;
  logic rd, adr, act;
  initial {act, sda_low, nack_seen, cnt} = 7'h0;
  // Start and stop seen as data edges while clock is high
  always @(negedge sda) if (scl) {cnt, adr, act} <= 6'h3;
  always @(posedge sda) if (scl) act <= 1'h0;
  // Shift in on rising clock, ninth bit is the handshake
  always @(posedge scl) if (act)
  begin
    if (cnt < 4'h8) sh <= {sh[6:0], sda};
    else if (adr) rd <= sh[0];
    else if (rd) nack_seen <= sda;
    else got <= sh;
    if (cnt == 4'h8) adr <= 1'h0;
    cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
  end
  // Change only on falling clock; ack unless the master is reading data
  always @(negedge scl) sda_low <= act && ((cnt == 4'h8 && !(rd && !adr)) ||
    (rd && !adr && cnt < 4'h8 && !tx_byte[3'h7 - cnt[2:0]]));
endmodule
`default_nettype wire

/* scl_tick_gen.v */
// Quarter-period tick generator for the master SCL
`timescale 1ns/1ps
`default_nettype none
`include "i2c_b_defines.vh"
module scl_tick_gen
(
  input wire sys_clk,
  input wire resetn,
  input wire run,
  input wire speed,
  input wire [2:0] div_sel,
  output reg tick,
  output reg [1:0] phase
);
  // ----------------------------------------
  // Divider lookup
  // ----------------------------------------
  // System clocks per SCL period
  function [7:0] div_of;
    input spd;
    input [2:0] sel;
    reg [7:0] f;
    begin
      f = `DIV_F0;
      case (sel)
        3'h1: f = `DIV_F1;
        3'h2: f = `DIV_F2;
        3'h3: f = `DIV_F3;
        3'h4: f = `DIV_F4;
        3'h5: f = `DIV_F5;
        3'h6: f = `DIV_F6;
        3'h7: f = `DIV_F7;
        default: f = `DIV_F0;
      endcase
      div_of = spd ? f : (f << `DIV_STD_SHIFT);
    end
  endfunction

  reg [7:0] cnt_r; // Position in SCL period
  wire [7:0] div_w = div_of(speed, div_sel);
  wire [7:0] q_w = {2'h0, div_w[7:2]}; // Quarter period
  wire [7:0] h_w = {q_w[6:0], 1'h0}; // Half period
  wire [7:0] t_w = q_w + h_w; // Three quarters

  // ----------------------------------------
  // Period counter and phase ticks
  // ----------------------------------------
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r <= 8'h00;
      tick <= 1'h0;
      phase <= 2'h0;
    end
    else if (!run)
    begin
      cnt_r <= 8'h00;
      tick <= 1'h0;
      phase <= 2'h0;
    end
    else
    begin
      cnt_r <= (cnt_r >= div_w - 8'h01) ? 8'h00 : cnt_r + 8'h01;
      tick <= (cnt_r == 8'h00) | (cnt_r == q_w) | (cnt_r == h_w) | (cnt_r == t_w);
      if (cnt_r == 8'h00)
        phase <= 2'h0;
      else if (cnt_r == q_w)
        phase <= 2'h1;
      else if (cnt_r == h_w)
        phase <= 2'h2;
      else
        phase <= 2'h3;
    end
  end
endmodule
`default_nettype wire

/* test_i2c_b_ctrl.sv */
// Self-checking bench for the second two-wire controller
`timescale 1ns/1ps
`default_nettype none
`include "i2c_b_defines.vh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module test_i2c_b_ctrl;
  logic sys_clk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [9:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] r, got;
  wire awready, wready, bvalid, arready, rvalid, scl_out, scl_oe, sda_out, sda_oe, m_low;
  wire nack_seen;
  wire scl_in = !scl_oe; // Pull-ups on both lines
  wire sda_in = !(sda_oe || m_low);
  int bad_count = 0, check_count = 0, cyc = 0;
  i2c_b_ctrl i2c_b_ctrl_i (.sys_clk, .resetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
    .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .scl_in,
    .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe);
  i2c_b_slave_model i2c_b_slave_model_i (.scl(scl_in), .sda(sda_in), .tx_byte(8'hc3),
    .sda_low(m_low), .got, .nack_seen);
  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cyc == 80000)
  begin
    bad_count++;
    close_out;
  end
  task automatic close_out;
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Register write and read over the bus, each channel held until taken
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge sys_clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {i, 2'h0, 24'h0, d, 3'h7};
    do
    begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    resp = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] i);
    @(posedge sys_clk);
    {araddr, arvalid, rready} <= {i, 2'h0, 2'h3};
    do
    begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    {resp, r} = {rresp, rdata[7:0]};
    rready <= 1'h0;
  endtask
  task automatic poll(input logic [7:0] m);
    int n;
    n = 0;
    do
    begin
      rd(`IDX_CR1);
      n++;
    end while ((r & m) != 8'h0 && n < 3000);
    `CHK("cr1 self clear", 8'h0, r & m)
  endtask
  task automatic t_reset;
    logic [7:0] idx [5] = '{`IDX_INT, `IDX_CR1, `IDX_CR2, `IDX_TA, `IDX_DB};
    logic [7:0] rv [5] = '{`RST_INT, `RST_CR1, `RST_CR2, `RST_TA, `RST_DB};
    for (int k = 0; k < 5; k++)
    begin
      rd(idx[k]);
      `CHK("reset value", rv[k], r)
    end
    rd(8'hd8);
    `CHK("unmapped resp", 2'h2, resp)
    wr(8'hd8, 8'h00);
    `CHK("unmapped write resp", 2'h2, resp)
  endtask
  // Master write: address, then one data byte with stop
  task automatic t_write;
    wr(`IDX_CR2, 8'h21);
    `CHK("write resp", 2'h0, resp)
    wr(`IDX_CR1, 8'h60);
    wr(`IDX_TA, 8'ha0);
    wr(`IDX_CR1, 8'he0);
    poll(8'h80);
    `CHK("addr sent and ack", 8'h0c, r & 8'h0c)
    wr(`IDX_DB, 8'h5a);
    rd(`IDX_CR1);
    `CHK("empty cleared", 8'h0, r & 8'h01)
    wr(`IDX_CR1, 8'hf0);
    poll(8'h10);
    `CHK("byte at slave", 8'h5a, got)
    rd(`IDX_INT);
    `CHK("tx event", 8'h80, r & 8'h80)
    wr(`IDX_INT, 8'h00);
    rd(`IDX_INT);
    `CHK("tx event cleared", 8'h00, r & 8'h80)
  endtask
  // Master read with stop: byte ends in no-ack, full flag cleared by read
  task automatic t_read;
    wr(`IDX_TA, 8'ha1);
    wr(`IDX_CR1, 8'he0);
    poll(8'h80);
    wr(`IDX_CR1, 8'hf0);
    poll(8'h10);
    `CHK("full set", 8'h02, r & 8'h02)
    `CHK("final no-ack", 1'h1, nack_seen)
    rd(`IDX_DB);
    `CHK("read byte", 8'hc3, r)
    rd(`IDX_CR1);
    `CHK("full cleared", 8'h00, r & 8'h02)
  endtask
  // One address byte; SCL period measured between two pulls low
  task automatic t_rate(input logic [7:0] c2, input logic [7:0] c1, input int p);
    int n;
    wr(`IDX_CR2, c2);
    wr(`IDX_TA, 8'ha0);
    wr(`IDX_CR1, c1);
    @(posedge scl_oe);
    n = cyc;
    @(posedge scl_oe);
    `CHK("scl period", p, cyc - n)
    poll(8'h80);
  endtask
  task automatic t_srst;
    wr(`IDX_CR2, 8'h01);
    rd(`IDX_CR2);
    `CHK("busy flags idle", 8'h01, r & 8'h91)
    `CHK("scl released", 1'h0, scl_oe)
    `CHK("line data", 2'h0, {scl_out, sda_out})
  endtask
  initial
  begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'h1;
    t_reset;
    t_write;
    t_read;
    t_rate(8'h2f, 8'he0, 60);
    t_rate(8'h2b, 8'hc0, 160);
    t_srst;
    close_out;
  end
endmodule
`default_nettype wire
